// ### dps_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] Local cpu sees the shared ram at 0080-00ff outside modes 3 and 4.
// [RQ2] In mode 3 the local cpu sees the shared ram at c080-c0ff.
// [RQ3] In mode 3 direct page-zero accesses do not reach the semaphores.
// [RQ4] In mode 4 the ram answers at offsets 80-ff of every page.
// [RQ5] System addresses 80-ff select the shared ram.
// [RQ6] System addresses 17-1c select the six semaphores.
// [RQ7] System writes to reserved addresses change nothing.
// [RQ8] System reads of reserved addresses return ff.
// [RQ9] Both sides reach the semaphores the way they reach the ram.
// [RQ10] The system port works either clocked by its enable or handshaked.
// [RQ11] A system write to a semaphore ignores the data lines.
// [RQ12] There are six independent semaphores.
// [RQ13] A lone read returns the flag and sets it; a write clears it.
// [RQ14] On a tied read of a clear flag the local cpu wins it.
// [RQ15] Bit 6 shows ownership per side and bits 0-5 read zero.
// [RQ16] Reset sets all flags; the system side owns only the second.
// [RQ17] Same-cycle contention resolves in one clock on synced strobes.
module dps_port
    import dps_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  op_mode,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_direct,
    input  wire logic [7:0]  cpu_wdata,
    output logic [7:0]       cpu_rdata,
    output logic             cpu_hit,
    input  wire logic [7:0]  sys_addr,
    input  wire logic [7:0]  sys_data_in,
    input  wire logic        sys_read_write,
    input  wire logic        sys_cs_n,
    input  wire logic        sys_e,
    input  wire logic        sys_sync_mode,
    output logic [7:0]       sys_data_out,
    output logic             sys_data_oe,
    output logic             sys_transfer_ack_n_out,
    output logic             sys_transfer_ack_n_oe
);
    // pins, filtered into the mclk domain
    logic [7:0]  sa_f;
    logic [7:0]  sd_f;
    logic        rw_f;
    logic        cs_n_f;
    logic        e_f;
    logic        sync_f;
    logic        e_prev_q;

    dps_sync #(.W(8), .RST(8'h00)) u_sync_addr (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (sys_addr),
        .q     (sa_f)
    );

    dps_sync #(.W(8), .RST(8'h00)) u_sync_data (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (sys_data_in),
        .q     (sd_f)
    );

    // cs idles high; strobes are synced before any arbitration
    dps_sync #(.W(4), .RST(4'h9)) u_sync_ctl (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({sys_cs_n, sys_read_write, sys_e, sys_sync_mode}),
        .q     ({cs_n_f, rw_f, e_f, sync_f})
    ); // RQ17

    // local cpu decode
    logic        mode_high;
    logic        mode_part;
    logic        cpu_ram_hit;
    logic        cpu_sem_hit;
    logic [2:0]  cpu_sidx;
    logic [6:0]  cpu_ridx;

    assign mode_high   = (op_mode == DPS_MODE_HIGH_RAM);
    assign mode_part   = (op_mode == DPS_MODE_PARTIAL);
    assign cpu_ridx    = cpu_addr[6:0];
    assign cpu_ram_hit = mode_high ?
        (cpu_addr[15:7] == DPS_CPU_RAM_HIGH[15:7]) : // RQ2
        mode_part ? cpu_addr[DPS_RAM_SEL_BIT] : // RQ4
        (cpu_addr[15:7] == DPS_CPU_RAM_LOW[15:7]); // RQ1
    // mode 3 sends direct page-zero cycles to the external bus instead
    assign cpu_sem_hit = (cpu_addr[15:8] == DPS_CPU_REG_PAGE[15:8])
                         && dps_is_sem(cpu_addr[7:0])
                         && !(mode_high && cpu_direct); // RQ3 RQ9
    assign cpu_sidx    = dps_sem_idx(cpu_addr[7:0]);

    // system port decode and access strobes
    dps_state_t  state_q;
    logic        e_rise;
    logic        e_fall;
    logic        async_go;
    logic        sync_rd_go;
    logic        sync_wr_go;
    logic        sys_go;
    logic        sys_ram_hit;
    logic        sys_sem_hit;
    logic [2:0]  sys_sidx;
    logic [6:0]  sys_ridx;

    assign e_rise      = e_f && !e_prev_q;
    assign e_fall      = !e_f && e_prev_q;
    assign async_go    = (state_q == DPS_IDLE) && !sync_f && !cs_n_f;
    assign sync_rd_go  = (state_q == DPS_IDLE) && sync_f && !cs_n_f
                         && rw_f && e_rise; // RQ10
    assign sync_wr_go  = (state_q == DPS_IDLE) && sync_f && !cs_n_f
                         && !rw_f && e_fall; // RQ10
    assign sys_go      = async_go || sync_rd_go || sync_wr_go;
    assign sys_ram_hit = sa_f[DPS_RAM_SEL_BIT]; // RQ5
    assign sys_sem_hit = dps_is_sem(sa_f); // RQ6
    assign sys_sidx    = dps_sem_idx(sa_f);
    assign sys_ridx    = sa_f[6:0];

    // semaphore bank
    logic        sem_cpu_rd;
    logic        sem_cpu_wr;
    logic        sem_sys_rd;
    logic        sem_sys_wr;
    logic [7:0]  sem_cpu_byte;
    logic [7:0]  sem_sys_byte;

    assign sem_cpu_rd = cpu_rd && cpu_sem_hit;
    assign sem_cpu_wr = cpu_wr && cpu_sem_hit;
    assign sem_sys_rd = sys_go && rw_f && sys_sem_hit;
    // sd_f is never looked at for a semaphore write
    assign sem_sys_wr = sys_go && !rw_f && sys_sem_hit; // RQ11

    dps_sem u_sem (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .cpu_rd    (sem_cpu_rd),
        .cpu_wr    (sem_cpu_wr),
        .cpu_idx   (cpu_sidx),
        .sys_rd    (sem_sys_rd),
        .sys_wr    (sem_sys_wr),
        .sys_idx   (sys_sidx),
        .cpu_rbyte (sem_cpu_byte),
        .sys_rbyte (sem_sys_byte)
    ); // RQ12

    // shared ram; a same-byte write clash is software's to avoid,
    // the local cpu simply wins the cycle
    logic [7:0]  ram_q [0:DPS_RAM_DEPTH-1];
    logic        ram_cpu_we;
    logic        ram_sys_we;

    assign ram_cpu_we = cpu_wr && cpu_ram_hit;
    // reserved addresses have no write path at all
    assign ram_sys_we = sys_go && !rw_f && sys_ram_hit; // RQ7

    always_ff @(posedge mclk) begin
        if (ram_cpu_we) begin
            ram_q[cpu_ridx] <= cpu_wdata;
        end
        if (ram_sys_we && !(ram_cpu_we && cpu_ridx == sys_ridx)) begin
            ram_q[sys_ridx] <= sd_f;
        end
    end

    // local read path
    logic [7:0]  cpu_rdata_q;
    logic [7:0]  cpu_rdata_d;
    logic        cpu_hit_q;
    logic        cpu_hit_d;

    assign cpu_hit_d   = cpu_rd && (cpu_ram_hit || cpu_sem_hit);
    assign cpu_rdata_d = !cpu_rd     ? cpu_rdata_q :
                         cpu_ram_hit ? ram_q[cpu_ridx] :
                         cpu_sem_hit ? sem_cpu_byte : 8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata_q <= 8'h00;
            cpu_hit_q   <= 1'b0;
        end else begin
            cpu_rdata_q <= cpu_rdata_d;
            cpu_hit_q   <= cpu_hit_d;
        end
    end

    assign cpu_rdata = cpu_rdata_q;
    assign cpu_hit   = cpu_hit_q;

    // system answer
    logic [7:0]  sys_rbyte;
    logic [7:0]  dout_q;
    logic        doe_q;
    logic        ack_q;
    logic        ack_oe_q;
    logic [3:0]  rel_cnt_q;
    logic        busy_end;

    assign sys_rbyte = sys_ram_hit ? ram_q[sys_ridx] :
                       sys_sem_hit ? sem_sys_byte :
                       DPS_RESERVED_READ; // RQ8
    // handshake holds until cs goes; clocked mode ends with the enable
    assign busy_end  = cs_n_f || (sync_f && e_fall);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            e_prev_q <= 1'b0;
        end else begin
            e_prev_q <= e_f;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= DPS_IDLE;
            dout_q    <= 8'h00;
            doe_q     <= 1'b0;
            ack_q     <= 1'b1;
            ack_oe_q  <= 1'b0;
            rel_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                DPS_IDLE: begin
                    if (async_go || sync_rd_go) begin
                        dout_q   <= sys_rbyte;
                        doe_q    <= rw_f;
                        ack_q    <= sync_f;
                        ack_oe_q <= !sync_f; // RQ10
                        state_q  <= DPS_BUSY;
                    end
                end
                DPS_BUSY: begin
                    if (busy_end) begin
                        doe_q <= 1'b0;
                        ack_q <= 1'b1;
                        if (ack_oe_q) begin
                            rel_cnt_q <= DPS_ACK_HIGH_CYC;
                            state_q   <= DPS_RELEASE;
                        end else begin
                            state_q <= DPS_IDLE;
                        end
                    end
                end
                DPS_RELEASE: begin
                    // drive high briefly so the line rises fast
                    if (rel_cnt_q == 4'h1) begin
                        ack_oe_q <= 1'b0;
                        state_q  <= DPS_IDLE;
                    end
                    rel_cnt_q <= rel_cnt_q - 4'h1;
                end
                default: begin
                    state_q <= DPS_IDLE;
                end
            endcase
        end
    end

    assign sys_data_out           = dout_q;
    assign sys_data_oe            = doe_q;
    assign sys_transfer_ack_n_out = ack_q;
    assign sys_transfer_ack_n_oe  = ack_oe_q;
endmodule

// ### dps_pkg.sv
package dps_pkg;

    // cpu-side windows onto the shared ram and the register page
    localparam logic [15:0] DPS_CPU_RAM_LOW     = 16'h0080;
    localparam logic [15:0] DPS_CPU_RAM_HIGH    = 16'hc080;
    localparam logic [15:0] DPS_CPU_REG_PAGE    = 16'h0000;

    // shared map, identical for both sides below the ram
    localparam logic [7:0]  DPS_SEM_FIRST       = 8'h17;
    localparam logic [7:0]  DPS_SEM_LAST        = 8'h1c;
    localparam int          DPS_SEM_COUNT       = 6;
    localparam int          DPS_RAM_DEPTH       = 128;
    localparam int          DPS_RAM_SEL_BIT     = 7;
    localparam logic [7:0]  DPS_RESERVED_READ   = 8'hff;

    // semaphore byte layout
    localparam int          DPS_SEM_FLAG_BIT    = 7;
    localparam int          DPS_SEM_OWN_BIT     = 6;

    // after reset: all flags set, local side owns all but the second
    localparam logic [5:0]  DPS_SEM_FLAG_RST    = 6'h3f;
    localparam logic [5:0]  DPS_SEM_OWN_RST     = 6'h3d;

    // operating modes that move the ram or cut register decode
    localparam logic [2:0]  DPS_MODE_HIGH_RAM   = 3'h3;
    localparam logic [2:0]  DPS_MODE_PARTIAL    = 3'h4;

    // acknowledge drive-high time before it is released
    localparam int          DPS_CLK_PERIOD_NS   = 5;
    localparam int          DPS_ACK_HIGH_NS     = 60;
    localparam int          DPS_ACK_HIGH_RAW    =
        DPS_ACK_HIGH_NS / DPS_CLK_PERIOD_NS;
    localparam logic [3:0]  DPS_ACK_HIGH_CYC    =
        4'((DPS_ACK_HIGH_RAW < 1) ? 1 : DPS_ACK_HIGH_RAW);

    typedef enum logic [1:0] {
        DPS_IDLE,
        DPS_BUSY,
        DPS_RELEASE
    } dps_state_t;

    function automatic logic dps_is_sem(input logic [7:0] a);
        dps_is_sem = (a >= DPS_SEM_FIRST) && (a <= DPS_SEM_LAST);
    endfunction

    function automatic logic [2:0] dps_sem_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - DPS_SEM_FIRST;
        dps_sem_idx = d[2:0];
    endfunction

endpackage

// ### dps_sync.sv
`timescale 1ns/10ps
module dps_sync
    import dps_pkg::*;
#(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;

    assign q = q_q;

    // a value only counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q_q  <= RST;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_q <= s3_q;
            end
        end
    end
endmodule

// ### dps_sem.sv
`timescale 1ns/10ps
module dps_sem
    import dps_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       cpu_rd,
    input  wire logic       cpu_wr,
    input  wire logic [2:0] cpu_idx,
    input  wire logic       sys_rd,
    input  wire logic       sys_wr,
    input  wire logic [2:0] sys_idx,
    output logic [7:0]      cpu_rbyte,
    output logic [7:0]      sys_rbyte
);
    logic [5:0] flag_q;
    logic [5:0] flag_d;
    logic [5:0] own_q;
    logic [5:0] own_d;
    logic       tie_read;

    // both read the same clear flag: local side gets it, system does not
    assign tie_read = cpu_rd && sys_rd && (cpu_idx == sys_idx)
                      && !flag_q[cpu_idx]; // RQ14

    always_comb begin
        flag_d = flag_q;
        own_d  = own_q;
        for (int i = 0; i < DPS_SEM_COUNT; i++) begin
            if (flag_q[i]) begin
                if ((cpu_wr && cpu_idx == 3'(i)) ||
                    (sys_wr && sys_idx == 3'(i))) begin
                    flag_d[i] = 1'b0; // RQ13
                end
            end else if (cpu_rd && cpu_idx == 3'(i)) begin
                // a read of a clear flag sets it, even against a write
                flag_d[i] = 1'b1; // RQ13
                own_d[i]  = 1'b1; // RQ15
            end else if (sys_rd && sys_idx == 3'(i)) begin
                flag_d[i] = 1'b1; // RQ13
                own_d[i]  = 1'b0; // RQ15
            end
        end
    end

    // low six bits read zero; ownership is mirrored per side
    assign cpu_rbyte = {flag_q[cpu_idx], own_q[cpu_idx], 6'h00}; // RQ15
    assign sys_rbyte = {flag_q[sys_idx] | tie_read,
                        ~own_q[sys_idx], 6'h00}; // RQ14

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= DPS_SEM_FLAG_RST; // RQ16
            own_q  <= DPS_SEM_OWN_RST; // RQ16
        end else begin
            flag_q <= flag_d;
            own_q  <= own_d;
        end
    end
endmodule

// ### dps_port_assertions.sv
`timescale 1ns/10ps
module dps_port_assertions
    import dps_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [2:0]  op_mode,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_rd,
    input wire logic        cpu_wr,
    input wire logic        cpu_direct,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        cpu_hit,
    input wire logic [7:0]  sys_addr,
    input wire logic [7:0]  sys_data_in,
    input wire logic        sys_read_write,
    input wire logic        sys_cs_n,
    input wire logic        sys_e,
    input wire logic        sys_sync_mode,
    input wire logic [7:0]  sys_data_out,
    input wire logic        sys_data_oe,
    input wire logic        sys_transfer_ack_n_out,
    input wire logic        sys_transfer_ack_n_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire m3    = op_mode == 3'h3;
    wire m4    = op_mode == 3'h4;
    wire sem_a = cpu_addr >= 16'h0017 && cpu_addr <= 16'h001c;
    low_ram_a: assert property (
        cpu_rd && !m3 && !m4 && cpu_addr[15:7] == 9'h001 |=> cpu_hit)
        else $error("low ram read missed");
    high_ram_a: assert property (
        cpu_rd && m3 && cpu_addr[15:7] == 9'h181 |=> cpu_hit)
        else $error("high ram read missed");
    low_gone_a: assert property (
        cpu_rd && m3 && cpu_addr[15:7] == 9'h001 |=> !cpu_hit)
        else $error("low page hit in mode 3");
    direct_cut_a: assert property (
        cpu_rd && m3 && cpu_direct && sem_a |=> !cpu_hit)
        else $error("direct semaphore access hit");
    partial_ram_a: assert property (
        cpu_rd && m4 && cpu_addr[7] |=> cpu_hit)
        else $error("partial decode read missed");
    sem_bits_a: assert property (
        cpu_rd && sem_a && !(m3 && cpu_direct)
        |=> cpu_hit && cpu_rdata[5:0] == 6'h00)
        else $error("semaphore low bits not zero");
    ack_tail_a: assert property (
        $rose(sys_transfer_ack_n_out) && sys_transfer_ack_n_oe
        |-> sys_transfer_ack_n_oe [*8] ##1 sys_transfer_ack_n_oe [*4]
        ##1 !sys_transfer_ack_n_oe)
        else $error("ack release time wrong");
    ack_driven_a: assert property (
        !sys_transfer_ack_n_out |-> sys_transfer_ack_n_oe)
        else $error("ack low while not driven");
    sync_quiet_a: assert property (
        $past(sys_sync_mode, 20) && sys_sync_mode
        |-> !sys_transfer_ack_n_oe)
        else $error("ack driven in clocked mode");
    cover property (cpu_hit && sem_a);
    cover property ($fell(sys_transfer_ack_n_out));
    cover property (sys_data_oe && sys_sync_mode);
endmodule

bind dps_port dps_port_assertions u_chk (
    .mclk(mclk), .rst_n(rst_n), .op_mode(op_mode), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_direct(cpu_direct),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit),
    .sys_addr(sys_addr), .sys_data_in(sys_data_in), .sys_e(sys_e),
    .sys_read_write(sys_read_write), .sys_cs_n(sys_cs_n),
    .sys_sync_mode(sys_sync_mode), .sys_data_out(sys_data_out),
    .sys_data_oe(sys_data_oe),
    .sys_transfer_ack_n_out(sys_transfer_ack_n_out),
    .sys_transfer_ack_n_oe(sys_transfer_ack_n_oe));

// ### dps_sys_master.sv
`timescale 1ns/10ps
module dps_sys_master (
    input  wire logic       mclk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       ack_out,
    input  wire logic       ack_oe,
    output logic [7:0]      addr,
    output logic [7:0]      data_in,
    output logic            read_write,
    output logic            cs_n,
    output logic            e,
    output logic            sync_mode,
    output logic            timed_out
);
    // pull-up holds the ack wire high when nobody drives it
    wire ack_n = ack_oe ? ack_out : 1'b1;
    initial begin
        {addr, data_in, read_write, e, timed_out} = '0;
        cs_n = 1'b1;
        sync_mode = 1'b1;
    end
    task automatic hs(input logic [7:0] a, input logic rw,
                      input logic [7:0] wd, output logic [7:0] r);
        int n;
        @(posedge mclk);
        {sync_mode, addr, read_write, data_in} <= {1'b0, a, rw, wd};
        repeat (8) @(posedge mclk);
        cs_n <= 1'b0;
        for (n = 0; n < 40 && ack_n !== 1'b0; n++) @(posedge mclk);
        timed_out <= timed_out | (n == 40);
        r = data_oe ? data_out : 8'hxx;
        cs_n <= 1'b1;
        // released lines show a changed value, not the last one
        addr <= ~a;
        data_in <= ~wd;
        for (n = 0; n < 40 && ack_oe !== 1'b0; n++) @(posedge mclk);
        timed_out <= timed_out | (n == 40);
    endtask
    task automatic sy(input logic [7:0] a, input logic rw,
                      input logic [7:0] wd, output logic [7:0] r);
        @(posedge mclk);
        sync_mode <= 1'b1;
        repeat (8) @(posedge mclk);
        {cs_n, addr, read_write, data_in} <= {1'b0, a, rw, wd};
        repeat (8) @(posedge mclk);
        e <= 1'b1;
        repeat (8) @(posedge mclk);
        r = data_oe ? data_out : 8'hxx;
        e <= 1'b0;
        repeat (8) @(posedge mclk);
        {cs_n, addr, data_in} <= {1'b1, ~a, ~wd};
        repeat (4) @(posedge mclk);
    endtask
endmodule

// ### dps_port_bench.sv
`timescale 1ns/10ps
module dps_port_bench
    import dps_pkg::*;
;
    logic        mclk, rst_n, cpu_rd, cpu_wr, cpu_direct, h;
    logic [2:0]  op_mode;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, rd, v, a;
    logic [5:0]  flag, own;
    wire  [7:0]  cpu_rdata, sa, sdi, sdo;
    wire         cpu_hit, srw, scs, se, ssy, soe, ako, akoe, tmo;
    int          mismatches, check_count, cyc, i, k;
    // reserved system addresses, both gaps and their edges
    logic [7:0]  rsv [0:4];

    dps_port dut (.mclk(mclk), .rst_n(rst_n), .op_mode(op_mode),
        .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
        .cpu_direct(cpu_direct), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .sys_addr(sa),
        .sys_data_in(sdi), .sys_read_write(srw), .sys_cs_n(scs),
        .sys_e(se), .sys_sync_mode(ssy), .sys_data_out(sdo),
        .sys_data_oe(soe), .sys_transfer_ack_n_out(ako),
        .sys_transfer_ack_n_oe(akoe));
    dps_sys_master sm (.mclk(mclk), .data_out(sdo), .data_oe(soe),
        .ack_out(ako), .ack_oe(akoe), .addr(sa), .data_in(sdi),
        .read_write(srw), .cs_n(scs), .e(se), .sync_mode(ssy),
        .timed_out(tmo));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000 || tmo === 1'b1) begin
            mismatches++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cpu_acc(input logic [15:0] ad, input logic w, input logic [7:0] wd,
                 output logic [7:0] r, output logic hit);
        @(posedge mclk);
        {cpu_addr, cpu_wr, cpu_rd, cpu_wdata} <= {ad, w, !w, wd};
        @(posedge mclk);
        {cpu_rd, cpu_wr} <= 2'b00;
        #1;
        r = cpu_rdata;
        hit = cpu_hit;
    endtask
    task sys_acc(input logic s, input logic [7:0] ad, input logic rw,
                 input logic [7:0] wd, output logic [7:0] r);
        if (s) sm.sy(ad, rw, wd, r);
        else sm.hs(ad, rw, wd, r);
    endtask
    task cpu_rd_chk(input logic [2:0] m, input logic [15:0] ad,
                    input logic [7:0] e);
        op_mode <= m;
        cpu_acc(ad, 1'b0, 8'h00, rd, h);
        chk("cpu hit", {7'h0, h}, 8'h01);
        chk("cpu ram", rd, e);
    endtask
    // test-and-set model; own bit set means the local side owns it
    task sem_op(input logic c, input int n, input logic w);
        logic [7:0] e;
        e = {flag[n], own[n] == c, 6'h00};
        if (c) cpu_acc(16'(16'h0017 + n), w, 8'($urandom), rd, h);
        else sys_acc(1'($urandom), 8'(8'h17 + n), !w, 8'($urandom), rd);
        if (!w) chk("semaphore", rd, e);
        if (w) flag[n] = 1'b0;
        else if (!flag[n]) {flag[n], own[n]} = {1'b1, c};
    endtask

    initial begin
        {mismatches, check_count, cyc} = '0;
        {rst_n, cpu_rd, cpu_wr, cpu_direct, op_mode} = '0;
        {cpu_addr, cpu_wdata} = '0;
        flag = 6'h3f;
        own = 6'h3d;
        void'($urandom(32'h5198));
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        for (i = 0; i < 6; i++) sem_op(1'b1, i, 1'b0);
        for (i = 0; i < 6; i++) sem_op(1'b0, i, 1'b0);
        v = 8'($urandom);
        sys_acc(1'b0, 8'hd5, 1'b0, v, rd);
        sys_acc(1'b0, 8'h55, 1'b0, ~v, rd);
        sys_acc(1'b1, 8'h16, 1'b0, ~v, rd);
        sys_acc(1'b0, 8'hd5, 1'b1, 8'h00, rd);
        chk("ram kept", rd, v);
        rsv = '{8'h00, 8'h16, 8'h1d, 8'h55, 8'h7f};
        for (k = 0; k < 5; k++) begin
            sys_acc(1'(k), rsv[k], 1'b1, 8'h00, rd);
            chk("reserved", rd, 8'hff);
        end
        for (k = 0; k < 40; k++) begin
            sem_op(1'($urandom), int'($urandom % 6), 1'($urandom));
        end
        for (k = 0; k < 6; k++) begin
            a = 8'($urandom) | 8'h80;
            v = 8'($urandom);
            op_mode <= 3'h0;
            sys_acc(1'(k), a, 1'b0, v, rd);
            cpu_rd_chk(3'h0, {8'h00, a}, v);
            cpu_rd_chk(3'h3, {8'hc0, a}, v);
            cpu_rd_chk(3'h4, {8'($urandom), a}, v);
            cpu_acc({8'h00, a}, 1'b1, ~v, rd, h);
            op_mode <= 3'h3;
            cpu_acc({8'h00, a}, 1'b0, 8'h00, rd, h);
            chk("low page", {7'h0, h}, 8'h00);
            sys_acc(1'(k + 1), a, 1'b1, 8'h00, rd);
            chk("sys ram", rd, ~v);
        end
        cpu_direct <= 1'b1;
        cpu_acc(16'h0017, 1'b0, 8'h00, rd, h);
        chk("direct sem", {7'h0, h}, 8'h00);
        cpu_direct <= 1'b0;
        sem_op(1'b1, 0, 1'b0);
        print_verdict();
    end
endmodule
